// [rtl/gfm_pkg.sv]
// Notes on behaviour
// - six pins, each set separately to plain input/output or a custom function
// - network status function on pins 1-4 drives the pattern for the network state
// - receiver supply function on pins 1-4 drives the receiver supply enable
// - data-ready sensing only on pin 3; receiver raises it, block senses it
// - pins set as input report their sampled level
// - pins set as output drive the level last written
// - every pin resets disabled: driver off, pull-down on; can return there
package gfm_pkg;
    // =========================================================
    // sizes
    localparam int unsigned PIN_COUNT = 6;
    localparam int unsigned FUNC_W    = 3;
    localparam int unsigned PIN_IDX_W = 3;
    localparam int unsigned NET_W     = 2;
    // only pin index 2 (the third pin) may sense receiver data ready
    localparam logic [PIN_IDX_W-1:0] DRDY_PIN      = 3'h2;
    // custom output functions live on the first four pins only
    localparam logic [PIN_IDX_W-1:0] LAST_CUST_PIN = 3'h3;

    // =========================================================
    // pin functions; disabled is the reset value
    typedef enum logic [FUNC_W-1:0] {
        GFM_FN_DISABLED = 3'h0,
        GFM_FN_INPUT    = 3'h1,
        GFM_FN_OUTPUT   = 3'h2,
        GFM_FN_NETSTAT  = 3'h3,
        GFM_FN_GNSS_PWR = 3'h4,
        GFM_FN_DRDY     = 3'h5
    } gfm_func_t;

    // network state as given by the modem core
    typedef enum logic [NET_W-1:0] {
        GFM_NET_NONE    = 2'h0,
        GFM_NET_HOME    = 2'h1,
        GFM_NET_ROAMING = 2'h2,
        GFM_NET_DATA    = 2'h3
    } gfm_net_t;

    // blink timing of the status indicator
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned BLINK_SLOW_US = 1000;
    localparam int unsigned BLINK_FAST_US = 250;
    localparam int unsigned SLOW_CYCLES   = BLINK_SLOW_US * CLK_MHZ;
    localparam int unsigned FAST_CYCLES   = BLINK_FAST_US * CLK_MHZ;
endpackage : gfm_pkg

// [rtl/gfm_blink.sv]
`timescale 1ns/1ns
// =========================================================
// blink generator: turns the network state into one indicator level
module gfm_blink
    import gfm_pkg::*;
#(
    parameter int unsigned SLOW = SLOW_CYCLES,  // slow half period in cycles
    parameter int unsigned FAST = FAST_CYCLES   // fast half period in cycles
)(
    input  wire logic           mclk,       // system clock
    input  wire logic           rst_n,      // synchronous reset
    input  wire gfm_pkg::gfm_net_t net,     // network state
    output logic                level       // indicator level
);
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic        tog;
    logic        next_tog;
    logic [31:0] half;

    // home is steady on, roaming slow, data fast, no service off
    always_comb
    begin
        half     = (net == GFM_NET_DATA) ? FAST : SLOW;
        next_cnt = cnt + 32'h1;
        next_tog = tog;
        if (cnt >= half - 32'h1)
        begin
            next_cnt = 32'h0;
            next_tog = ~tog;
        end
        case (net)
            GFM_NET_HOME:    level = 1'b1;
            GFM_NET_ROAMING: level = tog;
            GFM_NET_DATA:    level = tog;
            default:         level = 1'b0;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt <= 32'h0;
            tog <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tog <= next_tog;
        end
    end
endmodule // gfm_blink

// [rtl/gfm_gpio.sv]
`timescale 1ns/1ns
// =========================================================
// six-pin function mux with configuration and write commands, level and function readback
module gfm_gpio
    import gfm_pkg::*;
#(
    parameter int unsigned SLOW = SLOW_CYCLES,  // slow blink half period
    parameter int unsigned FAST = FAST_CYCLES   // fast blink half period
)(
    input  wire logic                 mclk,         // system clock, 250 MHz
    input  wire logic                 rst_n,        // synchronous reset, low
    input  wire logic                 cfg_valid,    // config command pulse
    input  wire logic [PIN_IDX_W-1:0] cfg_pin,      // pin index 0..5
    input  wire gfm_pkg::gfm_func_t   cfg_func,     // requested function
    output logic                      cfg_done,     // config accepted pulse
    output logic                      cfg_err,      // config refused pulse
    input  wire logic                 wr_valid,     // level write pulse
    input  wire logic [PIN_IDX_W-1:0] wr_pin,       // pin index to write
    input  wire logic                 wr_level,     // level to drive
    input  wire gfm_pkg::gfm_net_t    net_state,    // network state
    input  wire logic                 gnss_pwr_on,  // receiver supply request
    input  wire logic [PIN_COUNT-1:0] pin_in,       // pin input levels
    output logic [PIN_COUNT-1:0]      pin_out,      // pin output levels
    output logic [PIN_COUNT-1:0]      pin_oe,       // pin drive enables
    output logic [PIN_COUNT-1:0]      pin_pd,       // pull-down enables
    output logic [PIN_COUNT-1:0]      pin_level,    // sampled input levels
    output logic                      gnss_drdy,    // receiver data ready
    output logic [3*PIN_COUNT-1:0]    pin_func      // current function per pin
);
    gfm_func_t            func [PIN_COUNT];
    gfm_func_t            next_func [PIN_COUNT];
    logic [PIN_COUNT-1:0] wlev;
    logic [PIN_COUNT-1:0] next_wlev;
    logic [PIN_COUNT-1:0] sync1;
    logic [PIN_COUNT-1:0] sync2;
    logic                 next_done;
    logic                 next_err;
    logic                 legal;
    logic                 blink;
    logic [PIN_COUNT-1:0] next_out;
    logic [PIN_COUNT-1:0] next_oe;
    logic [PIN_COUNT-1:0] next_pd;
    logic [PIN_COUNT-1:0] next_lvl;
    logic                 next_drdy;

    gfm_blink #(.SLOW(SLOW), .FAST(FAST)) u_blink (
        .mclk  (mclk),
        .rst_n (rst_n),
        .net   (net_state),
        .level (blink)
    );

    // =========================================================
    // configuration: legality check, one function per pin
    always_comb
    begin
        case (cfg_func)
            GFM_FN_DISABLED, GFM_FN_INPUT, GFM_FN_OUTPUT:
                legal = (cfg_pin < PIN_IDX_W'(PIN_COUNT));
            GFM_FN_NETSTAT, GFM_FN_GNSS_PWR:
                legal = (cfg_pin <= LAST_CUST_PIN);
            GFM_FN_DRDY:
                legal = (cfg_pin == DRDY_PIN);
            default:
                legal = 1'b0;
        endcase
        next_done = cfg_valid && legal;
        next_err  = cfg_valid && !legal;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            next_func[i] = func[i];
            if (next_done && (cfg_pin == PIN_IDX_W'(i)))
                next_func[i] = cfg_func;
        end
        next_wlev = wlev;
        if (wr_valid && (wr_pin < PIN_IDX_W'(PIN_COUNT)))
            next_wlev[wr_pin] = wr_level;
    end

    // =========================================================
    // per-pin output mux; outputs registered so pins never glitch
    always_comb
    begin
        next_drdy = 1'b0;
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            next_out[i] = 1'b0;
            next_oe[i]  = 1'b0;
            next_pd[i]  = 1'b0;
            next_lvl[i] = 1'b0;
            case (func[i])
                GFM_FN_INPUT:    next_lvl[i] = sync2[i];
                GFM_FN_OUTPUT:
                begin
                    next_out[i] = wlev[i];
                    next_oe[i]  = 1'b1;
                end
                GFM_FN_NETSTAT:
                begin
                    next_out[i] = blink;
                    next_oe[i]  = 1'b1;
                end
                GFM_FN_GNSS_PWR:
                begin
                    next_out[i] = gnss_pwr_on;
                    next_oe[i]  = 1'b1;
                end
                GFM_FN_DRDY:
                begin
                    next_lvl[i] = sync2[i];
                    next_drdy   = sync2[i];
                end
                default:         next_pd[i] = 1'b1;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PIN_COUNT; i++)
                func[i] <= GFM_FN_DISABLED;
            wlev      <= '0;
            sync1     <= '0;
            sync2     <= '0;
            cfg_done  <= 1'b0;
            cfg_err   <= 1'b0;
            pin_out   <= '0;
            pin_oe    <= '0;
            pin_pd    <= '1;
            pin_level <= '0;
            gnss_drdy <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < PIN_COUNT; i++)
                func[i] <= next_func[i];
            wlev      <= next_wlev;
            sync1     <= pin_in;    // two-stage synchroniser for pin levels
            sync2     <= sync1;
            cfg_done  <= next_done;
            cfg_err   <= next_err;
            pin_out   <= next_out;
            pin_oe    <= next_oe;
            pin_pd    <= next_pd;
            pin_level <= next_lvl;
            gnss_drdy <= next_drdy;
        end
    end

    // function readback, flattened three bits per pin
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
            pin_func[FUNC_W*i +: FUNC_W] = func[i];
    end

    // =========================================================
    // checks: configuration commands
    a_bad_cfg_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_valid && cfg_func == GFM_FN_DRDY && cfg_pin != DRDY_PIN
        |=> cfg_err && $stable(pin_func)) else $error("bad cfg applied");
    a_pins_56_plain: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_valid && cfg_pin > LAST_CUST_PIN && cfg_func == GFM_FN_NETSTAT
        |=> cfg_err) else $error("custom fn on pin 5/6");
    a_refuse_range: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_valid && cfg_pin >= PIN_IDX_W'(PIN_COUNT)
        |=> cfg_err && $stable(pin_func)) else $error("missing pin configured");
    a_err_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_err |-> $stable(pin_func)) else $error("refused cfg changed a pin");
    a_done_err_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        !(cfg_done && cfg_err)) else $error("done and err together");

    // =========================================================
    // checks: plain pins
    a_out_follows_wr: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_valid && wr_pin == 3'h0 && func[0] == GFM_FN_OUTPUT && !cfg_valid
        |=> ##1 pin_out[0] == $past(wr_level, 2) && pin_oe[0])
        else $error("output level wrong");
    a_wr_range_ign: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_valid && wr_pin >= PIN_IDX_W'(PIN_COUNT) |=> $stable(wlev))
        else $error("write to missing pin stored");
    a_in_level_lat: assert property (@(posedge mclk) disable iff (!rst_n)
        func[1] == GFM_FN_INPUT && $past(func[1]) == GFM_FN_INPUT
        |-> pin_level[1] == $past(pin_in[1], 3) || $changed(func[1]))
        else $error("input level wrong");
    a_input_hiz: assert property (@(posedge mclk) disable iff (!rst_n)
        func[3] == GFM_FN_INPUT |=> !pin_oe[3] && !pin_pd[3])
        else $error("input pin driven or pulled");
    a_disabled_pd: assert property (@(posedge mclk) disable iff (!rst_n)
        func[4] == GFM_FN_DISABLED |=> pin_pd[4] && !pin_oe[4])
        else $error("disabled pin driven");
    a_oe_pd_excl: assert property (@(posedge mclk) disable iff (!rst_n)
        !(|(pin_oe & pin_pd))) else $error("pull-down on driven pin");

    // =========================================================
    // checks: custom functions
    a_gnss_pwr_pin: assert property (@(posedge mclk) disable iff (!rst_n)
        func[1] == GFM_FN_GNSS_PWR |=> pin_out[1] == $past(gnss_pwr_on) && pin_oe[1])
        else $error("supply enable wrong");
    a_home_steady: assert property (@(posedge mclk) disable iff (!rst_n)
        func[0] == GFM_FN_NETSTAT && net_state == GFM_NET_HOME |=> pin_out[0])
        else $error("home status not on");
    a_status_none: assert property (@(posedge mclk) disable iff (!rst_n)
        func[0] == GFM_FN_NETSTAT && net_state == GFM_NET_NONE |=> !pin_out[0] && pin_oe[0])
        else $error("no service status not off");
    a_drdy_only3: assert property (@(posedge mclk) disable iff (!rst_n)
        gnss_drdy |-> $past(func[2]) == GFM_FN_DRDY)
        else $error("data ready from wrong pin");
    a_drdy_applied: assert property (@(posedge mclk) disable iff (!rst_n)
        cfg_valid && cfg_pin == DRDY_PIN && cfg_func == GFM_FN_DRDY
        |=> cfg_done && func[DRDY_PIN] == GFM_FN_DRDY)
        else $error("data ready cfg lost");
    // three cycles of role history keep this clear of synchroniser contents
    // left over from before the pin took up data ready sensing
    a_drdy_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        func[DRDY_PIN] == GFM_FN_DRDY && $past(func[DRDY_PIN]) == GFM_FN_DRDY
        && $past(func[DRDY_PIN], 2) == GFM_FN_DRDY
        |-> gnss_drdy == $past(pin_in[DRDY_PIN], 3))
        else $error("data ready level wrong");

    // =========================================================
    // coverage of the main scenarios
    c_cfg_applied:  cover property (@(posedge mclk) cfg_done);
    c_cfg_refused:  cover property (@(posedge mclk) cfg_err);
    c_drdy_seen:    cover property (@(posedge mclk) gnss_drdy);
    c_out_high:     cover property (@(posedge mclk) pin_oe[5] && pin_out[5]);
    c_status_blink: cover property (@(posedge mclk) pin_oe[0] && $rose(pin_out[0]));
endmodule // gfm_gpio

// [verif/gfm_pin_model.sv]
`timescale 1ns/1ns
// =========================================================
// board and positioning receiver on the six pins
module gfm_pin_model
    import gfm_pkg::*;
(
    input  wire logic [PIN_COUNT-1:0] pin_out,  // device drive levels
    input  wire logic [PIN_COUNT-1:0] pin_oe,   // device drive enables
    input  wire logic [PIN_COUNT-1:0] pin_pd,   // device pull-downs
    input  wire logic [PIN_COUNT-1:0] ext_en,   // board drives these pins
    input  wire logic [PIN_COUNT-1:0] ext_lvl,  // board levels
    input  wire logic                 drdy,     // receiver has data to send
    output logic [PIN_COUNT-1:0]      pin_in    // resolved pin levels
);
    // device drive wins; a released pin without pull-down floats high here
    always_comb
    begin
        for (int i = 0; i < PIN_COUNT; i++)
        begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (i == 2 && ext_en[i])
                pin_in[i] = drdy;
            else if (ext_en[i])
                pin_in[i] = ext_lvl[i];
            else
                pin_in[i] = !pin_pd[i];
        end
    end
endmodule // gfm_pin_model

// [verif/gpio_function_mux_bench.sv]
`timescale 1ns/1ns
module gpio_function_mux_bench;
    import gfm_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cfg_valid = 1'b0;
    logic [2:0]  cfg_pin = 3'h0;
    gfm_func_t   cfg_func = GFM_FN_DISABLED;
    logic        wr_valid = 1'b0;
    logic [2:0]  wr_pin = 3'h0;
    logic        wr_level = 1'b0;
    gfm_net_t    net_state = GFM_NET_NONE;
    logic        gnss_pwr_on = 1'b0;
    logic [5:0]  ext_en = 6'h00;
    logic [5:0]  ext_lvl = 6'h00;
    logic        drdy = 1'b0;
    logic        cfg_done, cfg_err, gnss_drdy;
    logic [5:0]  pin_in, pin_out, pin_oe, pin_pd, pin_level;
    logic [17:0] pin_func;
    logic [17:0] exp_fn = 18'h0;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          cr, cd;

    gfm_gpio #(.SLOW(4), .FAST(2)) dut (.mclk(mclk), .rst_n(rst_n), .cfg_valid(cfg_valid),
        .cfg_pin(cfg_pin), .cfg_func(cfg_func), .cfg_done(cfg_done), .cfg_err(cfg_err),
        .wr_valid(wr_valid), .wr_pin(wr_pin), .wr_level(wr_level), .net_state(net_state),
        .gnss_pwr_on(gnss_pwr_on), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pd(pin_pd), .pin_level(pin_level), .gnss_drdy(gnss_drdy), .pin_func(pin_func));
    gfm_pin_model board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pd(pin_pd),
        .ext_en(ext_en), .ext_lvl(ext_lvl), .drdy(drdy), .pin_in(pin_in));

    // =========================================================
    // clock and hang guard; the run needs well under 2000 cycles
    always #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            end_of_test();
        end
    end

    // =========================================================
    // access tasks; all start and end at a falling edge
    task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cfg(input logic [2:0] pin, input logic [2:0] fn);
        logic ok;
        ok = pin < 3'h6 && (fn <= 3'h2 || (fn <= 3'h4 && pin <= 3'h3)
             || (fn == 3'h5 && pin == 3'h2));
        // idle edge first, so a strobe is never dropped and raised in one step
        @(negedge mclk);
        cfg_valid = 1'b1;
        cfg_pin = pin;
        cfg_func = gfm_func_t'(fn);
        @(posedge mclk);
        @(negedge mclk);
        cfg_valid = 1'b0;
        if (ok)
            exp_fn[3*pin +: 3] = fn;
        check("cfg_done", {17'h0, ok}, {17'h0, cfg_done});
        check("cfg_err", {17'h0, !ok}, {17'h0, cfg_err});
        check("pin_func", exp_fn, pin_func);
    endtask

    task automatic wr(input logic [2:0] pin, input logic lvl);
        @(negedge mclk);
        wr_valid = 1'b1;
        wr_pin = pin;
        wr_level = lvl;
        @(posedge mclk);
        @(negedge mclk);
        wr_valid = 1'b0;
    endtask

    // counts level changes of pin one over 24 cycles
    task automatic toggles(output int n);
        logic last;
        n = 0;
        last = pin_out[0];
        repeat (24)
        begin
            @(negedge mclk);
            if (pin_out[0] !== last)
                n++;
            last = pin_out[0];
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // =========================================================
    // test sequence
    initial
    begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        check("reset pd", 18'h3f, {12'h0, pin_pd});
        check("reset oe", 18'h0, {12'h0, pin_oe});
        $display("test reset done");
        // every code on every index, out-of-range ones included
        for (int p = 0; p < 8; p++)
            for (int f = 0; f < 8; f++)
                cfg(p[2:0], f[2:0]);
        $display("test legality done");
        for (int p = 0; p < 6; p++)
            cfg(p[2:0], 3'h2);
        // levels p0^p2 put pins at index 1, 3 and 4 high
        for (int p = 0; p < 6; p++)
            wr(p[2:0], p[0] ^ p[2]);
        wr(3'h6, 1'b1);
        repeat (2) @(negedge mclk);
        check("out oe", 18'h3f, {12'h0, pin_oe});
        check("out lvl", 18'h1a, {12'h0, pin_out});
        $display("test output done");
        ext_en = 6'h3f;
        ext_lvl = 6'h29;
        for (int p = 0; p < 6; p++)
            cfg(p[2:0], 3'h1);
        repeat (4) @(negedge mclk);
        check("in lvl", 18'h29, {12'h0, pin_level});
        check("in oe", 18'h0, {12'h0, pin_oe});
        cfg(3'h2, 3'h5);
        drdy = 1'b1;
        repeat (4) @(negedge mclk);
        check("drdy hi", 18'h1, {17'h0, gnss_drdy});
        drdy = 1'b0;
        repeat (4) @(negedge mclk);
        check("drdy lo", 18'h0, {17'h0, gnss_drdy});
        $display("test input done");
        ext_en = 6'h00;
        cfg(3'h1, 3'h4);
        gnss_pwr_on = 1'b1;
        repeat (2) @(negedge mclk);
        check("pwr on", 18'h3, {16'h0, pin_oe[1], pin_out[1]});
        gnss_pwr_on = 1'b0;
        repeat (2) @(negedge mclk);
        check("pwr off", 18'h2, {16'h0, pin_oe[1], pin_out[1]});
        $display("test supply done");
        cfg(3'h0, 3'h3);
        net_state = GFM_NET_HOME;
        repeat (12) @(negedge mclk);
        check("home", 18'h3, {16'h0, pin_oe[0], pin_out[0]});
        net_state = GFM_NET_NONE;
        repeat (12) @(negedge mclk);
        check("none", 18'h2, {16'h0, pin_oe[0], pin_out[0]});
        net_state = GFM_NET_ROAMING;
        toggles(cr);
        net_state = GFM_NET_DATA;
        toggles(cd);
        check("roam blinks", 18'h1, {17'h0, cr > 0});
        check("data faster", 18'h1, {17'h0, cd > cr});
        $display("test status done");
        for (int p = 0; p < 6; p++)
            cfg(p[2:0], 3'h0);
        repeat (2) @(negedge mclk);
        check("off pd", 18'h3f, {12'h0, pin_pd});
        check("off oe", 18'h0, {12'h0, pin_oe});
        $display("test disable done");
        end_of_test();
    end
endmodule // gpio_function_mux_bench
